// ===== verilog/frra_bank.sv
// Register bank of the line framer: real-time ops, indicator and status registers, frame timer,
// event flags and command storage. Assumes the host port and receive framer run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "frra_defines.svh"
module frra_bank import frra_pkg::*; #(
	parameter int FRAME_CYC = `FRRA_FRAME_CYC,
	parameter int SETTLE_CYC = `FRRA_SETTLE_CYC,
	parameter int MEM_DEPTH = 128
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] host_addr,
	input wire frra_byte_t host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output frra_byte_t host_rdata_r,
	output logic host_rvalid_r,
	input wire logic rx_frame_strobe,
	input wire logic [`FRRA_RT_BITS-1:0] rx_ops_in,
	input wire logic [`FRRA_RT_BITS-1:0] indicator_bits_in,
	input wire frra_byte_t rx_status_in,
	output logic [`FRRA_RT_BITS-1:0] tx_ops_channel_bits_r,
	output logic [`FRRA_RT_BITS-1:0] tx_indicator_bits_r,
	output logic tx_frame_tick_r,
	output logic rx_frame_tick_r,
	output logic window_open_r,
	output logic [1:0] event_flag_register_r,
	output frra_byte_t common_cmd_r
);
	// Elaboration checks on timing and memory size
	if (SETTLE_CYC < 1 || SETTLE_CYC >= FRAME_CYC) begin : g_bad_timing
		$error("frra_bank: frame timing parameters out of range");
	end
	if (MEM_DEPTH != 128) begin : g_bad_depth
		$error("frra_bank: command memory must hold 128 bytes");
	end

	// Maps an address to a command memory slot; bit 7 flags a mapped slot
	function automatic logic [7:0] mem_slot(input logic [7:0] a);
		logic [2:0] grp;
		logic hit;
		grp = 3'h0;
		hit = 1'b1;
		case (a[7:4])
			4'h8: begin
				grp = 3'h0;
				hit = (a[3:0] > 4'h3);
			end
			4'h9: grp = 3'h1;
			4'ha: grp = 3'h2;
			4'hb: grp = 3'h3;
			4'hc: grp = 3'h4;
			4'hd: begin
				grp = 3'h5;
				hit = (a != `FRRA_OFS_EVENT_FLAGS);
			end
			4'hf: grp = 3'h6;
			default: hit = 1'b0;
		endcase
		return {hit, grp, a[3:0]};
	endfunction

	// Frame timer and access phase
	logic [31:0] frame_cnt_r, frame_cnt_nxt;
	logic tx_frame_tick_nxt, rx_frame_tick_nxt, window_open_nxt;
	frra_phase_e phase_r, phase_nxt;

	always_comb begin
		frame_cnt_nxt = frame_cnt_r + 32'h1;
		tx_frame_tick_nxt = 1'b0;
		phase_nxt = phase_r;
		if (frame_cnt_r == 32'(FRAME_CYC - 1)) begin
			frame_cnt_nxt = 32'h0;
			tx_frame_tick_nxt = 1'b1;
		end
		case (phase_r)
			FRRA_SETTLE: if (frame_cnt_r == 32'(SETTLE_CYC - 1)) phase_nxt = FRRA_WINDOW;
			FRRA_WINDOW: if (tx_frame_tick_nxt || rx_frame_strobe) phase_nxt = FRRA_SETTLE;
			default: phase_nxt = FRRA_SETTLE;
		endcase
		if (rx_frame_strobe) phase_nxt = FRRA_SETTLE;
		rx_frame_tick_nxt = rx_frame_strobe;
		window_open_nxt = (phase_nxt == FRRA_WINDOW);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			frame_cnt_r <= 32'h0;
			phase_r <= FRRA_SETTLE;
			tx_frame_tick_r <= 1'b0;
			rx_frame_tick_r <= 1'b0;
			window_open_r <= 1'b0;
		end else if (clk_en) begin
			frame_cnt_r <= frame_cnt_nxt;
			phase_r <= phase_nxt;
			tx_frame_tick_r <= tx_frame_tick_nxt;
			rx_frame_tick_r <= rx_frame_tick_nxt;
			window_open_r <= window_open_nxt;
		end
	end

	// Real-time registers and event flags
	logic [`FRRA_RT_BITS-1:0] tx_ops_r, tx_ops_nxt, tx_ind_r, tx_ind_nxt;
	logic [`FRRA_RT_BITS-1:0] rx_ops_r, rx_ops_nxt, rx_ind_r, rx_ind_nxt;
	logic [`FRRA_RT_BITS-1:0] tx_ops_channel_bits_nxt, tx_indicator_bits_nxt;
	frra_byte_t rx_stat_r, rx_stat_nxt;
	logic [1:0] event_flag_register_nxt;
	logic wr_go, rd_go;

	assign wr_go = host_wr;
	assign rd_go = host_rd;

	always_comb begin
		tx_ops_nxt = tx_ops_r;
		tx_ind_nxt = tx_ind_r;
		if (wr_go) begin
			case (host_addr)
				`FRRA_OFS_TX_OPS_LO: tx_ops_nxt[7:0] = host_wdata;
				`FRRA_OFS_TX_OPS_HI: tx_ops_nxt[12:8] = host_wdata[`FRRA_HI_BITS-1:0];
				`FRRA_OFS_TX_IND_LO: tx_ind_nxt[7:0] = host_wdata;
				`FRRA_OFS_TX_IND_HI: tx_ind_nxt[12:8] = host_wdata[`FRRA_HI_BITS-1:0];
				default: begin
				end
			endcase
		end
		tx_ops_channel_bits_nxt = tx_ops_channel_bits_r;
		tx_indicator_bits_nxt = tx_indicator_bits_r;
		if (tx_frame_tick_nxt) begin
			tx_ops_channel_bits_nxt = tx_ops_r;
			tx_indicator_bits_nxt = tx_ind_r;
		end
		// Receive registers are read-only and fed only from the line side
		rx_ops_nxt = rx_frame_strobe ? rx_ops_in : rx_ops_r;
		rx_ind_nxt = rx_frame_strobe ? indicator_bits_in : rx_ind_r;
		rx_stat_nxt = rx_frame_strobe ? rx_status_in : rx_stat_r;
		event_flag_register_nxt = event_flag_register_r;
		if (rd_go && host_addr == `FRRA_OFS_EVENT_FLAGS) event_flag_register_nxt = `FRRA_RST_FLAGS;
		if (tx_frame_tick_nxt) event_flag_register_nxt[`FRRA_FLAG_TX_POS] = 1'b1;
		if (rx_frame_strobe) event_flag_register_nxt[`FRRA_FLAG_RX_POS] = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tx_ops_r <= `FRRA_RST_RT;
			tx_ind_r <= `FRRA_RST_RT;
			rx_ops_r <= `FRRA_RST_RT;
			rx_ind_r <= `FRRA_RST_RT;
			rx_stat_r <= `FRRA_RST_BYTE;
			tx_ops_channel_bits_r <= `FRRA_RST_RT;
			tx_indicator_bits_r <= `FRRA_RST_RT;
			event_flag_register_r <= `FRRA_RST_FLAGS;
		end else if (clk_en) begin
			tx_ops_r <= tx_ops_nxt;
			tx_ind_r <= tx_ind_nxt;
			rx_ops_r <= rx_ops_nxt;
			rx_ind_r <= rx_ind_nxt;
			rx_stat_r <= rx_stat_nxt;
			tx_ops_channel_bits_r <= tx_ops_channel_bits_nxt;
			tx_indicator_bits_r <= tx_indicator_bits_nxt;
			event_flag_register_r <= event_flag_register_nxt;
		end
	end

	// Command storage and common control
	logic [7:0] slot;
	frra_byte_t mem_rd;
	frra_byte_t common_cmd_nxt;

	assign slot = mem_slot(host_addr);

	frra_byte_mem #(
		.DEPTH(MEM_DEPTH),
		.AW(7)
	) u_mem (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.wr_en(wr_go && slot[7]),
		.wr_addr(slot[6:0]),
		.wr_data(host_wdata),
		.rd_addr(slot[6:0]),
		.rd_data_r(mem_rd)
	);

	always_comb begin
		common_cmd_nxt = common_cmd_r;
		if (wr_go && host_addr == `FRRA_OFS_COMMON_CMD) common_cmd_nxt = host_wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			common_cmd_r <= `FRRA_RST_BYTE;
		end else if (clk_en) begin
			common_cmd_r <= common_cmd_nxt;
		end
	end

	// Read path: two cycles from strobe to data
	frra_sel_e sel_r, sel_nxt;
	frra_byte_t local_r, local_nxt, host_rdata_nxt;
	logic pend_r, pend_nxt, host_rvalid_nxt;

	always_comb begin
		local_nxt = `FRRA_RST_BYTE;
		sel_nxt = FRRA_SEL_NONE;
		case (host_addr)
			`FRRA_OFS_TX_OPS_LO: local_nxt = tx_ops_r[7:0];
			`FRRA_OFS_TX_OPS_HI: local_nxt = {3'h0, tx_ops_r[12:8]};
			`FRRA_OFS_TX_IND_LO: local_nxt = tx_ind_r[7:0];
			`FRRA_OFS_TX_IND_HI: local_nxt = {3'h0, tx_ind_r[12:8]};
			`FRRA_OFS_EVENT_FLAGS: local_nxt = {6'h00, event_flag_register_r};
			`FRRA_OFS_RX_OPS_LO: local_nxt = rx_ops_r[7:0];
			`FRRA_OFS_RX_OPS_HI: local_nxt = {3'h0, rx_ops_r[12:8]};
			`FRRA_OFS_RX_IND_LO: local_nxt = rx_ind_r[7:0];
			`FRRA_OFS_RX_IND_HI: local_nxt = {3'h0, rx_ind_r[12:8]};
			`FRRA_OFS_RX_STATUS: local_nxt = rx_stat_r;
			default: local_nxt = `FRRA_RST_BYTE;
		endcase
		if (slot[7]) sel_nxt = FRRA_SEL_MEM;
		else if (host_addr[7:4] == 4'h8 || host_addr[7:4] == 4'he || host_addr == `FRRA_OFS_EVENT_FLAGS) sel_nxt = FRRA_SEL_LOCAL;
		pend_nxt = rd_go;
		host_rvalid_nxt = pend_r;
		host_rdata_nxt = host_rdata_r;
		if (pend_r) begin
			case (sel_r)
				FRRA_SEL_LOCAL: host_rdata_nxt = local_r;
				FRRA_SEL_MEM: host_rdata_nxt = mem_rd;
				default: host_rdata_nxt = `FRRA_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sel_r <= FRRA_SEL_NONE;
			local_r <= `FRRA_RST_BYTE;
			pend_r <= 1'b0;
			host_rvalid_r <= 1'b0;
			host_rdata_r <= `FRRA_RST_BYTE;
		end else if (clk_en) begin
			sel_r <= sel_nxt;
			local_r <= local_nxt;
			pend_r <= pend_nxt;
			host_rvalid_r <= host_rvalid_nxt;
			host_rdata_r <= host_rdata_nxt;
		end
	end

	// Checks
	a_narrow_mask: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) host_rd && host_addr == `FRRA_OFS_TX_OPS_HI ##2 host_rvalid_r |-> host_rdata_r[7:5] == 3'h0) else $error("narrow register upper bits not zero");
	a_bit_zero: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) host_rd && host_addr == `FRRA_OFS_TX_OPS_LO |-> ##2 host_rdata_r[0] == $past(tx_ops_r[0], 2)) else $error("bit zero mismatch");
	a_any_order: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) host_rd |-> ##2 host_rvalid_r) else $error("read not answered in two cycles");
	a_read_back: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) host_wr && host_addr == `FRRA_OFS_TX_IND_LO ##1 !host_wr ##1 host_rd && host_addr == `FRRA_OFS_TX_IND_LO && !host_wr |-> ##2 host_rdata_r == $past(host_wdata, 4)) else $error("write not read back");
	a_rx_capture: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) rx_frame_strobe |=> rx_ops_r == $past(rx_ops_in) && rx_stat_r == $past(rx_status_in)) else $error("receive registers not refreshed");
	a_event_flag: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) $rose(tx_frame_tick_r) |-> event_flag_register_r[`FRRA_FLAG_TX_POS]) else $error("transmit event flag missing");
	a_rx_only_line: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) !rx_frame_strobe |=> $stable(rx_ops_r) && $stable(rx_ind_r)) else $error("receive register changed without frame");
	a_common_cmd: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) host_wr && host_addr == `FRRA_OFS_COMMON_CMD |=> common_cmd_r == $past(host_wdata)) else $error("common command not taken");
	a_tx_capture: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) tx_frame_tick_r |-> tx_ops_channel_bits_r == $past(tx_ops_r)) else $error("transmit ops not captured");
	a_window_shut: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en) tx_frame_tick_r || rx_frame_tick_r |-> !window_open_r) else $error("window open at frame start");
	c_tx_frame: cover property (@(posedge sys_clk) disable iff (sys_rst) tx_frame_tick_r);
	c_rx_frame: cover property (@(posedge sys_clk) disable iff (sys_rst) rx_frame_tick_r);
	c_window: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(window_open_r));
	c_mem_read: cover property (@(posedge sys_clk) disable iff (sys_rst) host_rvalid_r && sel_r == FRRA_SEL_MEM);
endmodule // frra_bank
`default_nettype wire

// ===== verilog/frra_defines.svh
// Constants of the framer register bank: offsets, widths, reset values and frame timing.
// Assumes a single 200 MHz system clock; included by bare name from the package and the modules.
// How it works
// - Narrow registers keep their bits low; upper bits are dropped on write, read zero
// - Bit position 0 is the least significant bit of every register
// - Any register may be read or written at any time clk_en is high, in any order
// - Written values read back unchanged except read-only real-time registers, the event flags and the dropped upper bits of narrow registers
// - Receive ops, indicator and status registers refresh each frame; unread content is lost
// - Event flag bits show which real-time group was just updated
// - Transmit and receive registers reach only the line side of the framer
// - Common registers steer the voice-sample interface and synthesiser
// - Transmit ops and indicator bits are captured each transmit frame and resent
`ifndef FRRA_DEFINES_SVH
`define FRRA_DEFINES_SVH

`define FRRA_CLK_MHZ 200
`define FRRA_FRAME_MS 6
`define FRRA_SETTLE_MS 1
`define FRRA_FRAME_CYC (`FRRA_FRAME_MS * 1000 * `FRRA_CLK_MHZ)
`define FRRA_SETTLE_CYC (`FRRA_SETTLE_MS * 1000 * `FRRA_CLK_MHZ)

`define FRRA_OFS_TX_OPS_LO 8'h80
`define FRRA_OFS_TX_OPS_HI 8'h81
`define FRRA_OFS_TX_IND_LO 8'h82
`define FRRA_OFS_TX_IND_HI 8'h83
`define FRRA_OFS_EVENT_FLAGS 8'hd0
`define FRRA_OFS_RX_OPS_LO 8'he0
`define FRRA_OFS_RX_OPS_HI 8'he1
`define FRRA_OFS_RX_IND_LO 8'he2
`define FRRA_OFS_RX_IND_HI 8'he3
`define FRRA_OFS_RX_STATUS 8'he5
`define FRRA_OFS_COMMON_CMD 8'hc0

`define FRRA_RT_BITS 13
`define FRRA_HI_BITS 5
`define FRRA_FLAG_TX_POS 0
`define FRRA_FLAG_RX_POS 1
`define FRRA_RST_RT 13'h0000
`define FRRA_RST_BYTE 8'h00
`define FRRA_RST_FLAGS 2'h0

`endif

// ===== verilog/frra_pkg.sv
// Types shared by the framer register bank modules.
// Assumes the defines header is available on the include path.
`include "frra_defines.svh"
package frra_pkg;
	typedef enum logic [1:0] {
		FRRA_SETTLE = 2'h1,
		FRRA_WINDOW = 2'h2
	} frra_phase_e;

	typedef enum logic [2:0] {
		FRRA_SEL_LOCAL = 3'h1,
		FRRA_SEL_MEM = 3'h2,
		FRRA_SEL_NONE = 3'h4
	} frra_sel_e;

	typedef logic [7:0] frra_byte_t;
endpackage

// ===== verilog/frra_byte_mem.sv
// Byte memory holding the non-real-time command registers.
// Assumes one write and one read port on the system clock; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
`include "frra_defines.svh"
module frra_byte_mem import frra_pkg::*; #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire frra_byte_t wr_data,
	input wire logic [AW-1:0] rd_addr,
	output frra_byte_t rd_data_r
);
	// Elaboration check on the memory shape
	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
		$error("frra_byte_mem: depth does not fit address width");
	end

	frra_byte_t mem [DEPTH];
	frra_byte_t rd_data_nxt;

	always_comb begin
		rd_data_nxt = mem[rd_addr];
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_data_r <= `FRRA_RST_BYTE;
		end else if (clk_en) begin
			rd_data_r <= rd_data_nxt;
		end
	end
endmodule // frra_byte_mem
`default_nettype wire

// ===== verif/frra_rx_framer.sv
// Receive framer model: sends one frame of ops, indicator and status values per request.
// Assumes a go pulse from the bench, sampled on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module frra_rx_framer import frra_pkg::*; (
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [12:0] ops,
	input wire logic [12:0] indicator_bits,
	input wire frra_byte_t stat,
	output logic rx_frame_strobe,
	output logic [12:0] rx_ops_in,
	output logic [12:0] indicator_bits_in,
	output frra_byte_t rx_status_in
);
	logic req_r = 1'b0;
	initial begin
		rx_frame_strobe = 1'b0;
		rx_ops_in = 13'h0000;
		indicator_bits_in = 13'h0000;
		rx_status_in = 8'h00;
	end
	always @(posedge sys_clk) req_r <= go;
	// Fresh frame content for one cycle, then stale lines are inverted
	always @(negedge sys_clk) begin
		if (req_r) begin
			rx_frame_strobe = 1'b1;
			rx_ops_in = ops;
			indicator_bits_in = indicator_bits;
			rx_status_in = stat;
		end else if (rx_frame_strobe) begin
			rx_frame_strobe = 1'b0;
			rx_ops_in = ~rx_ops_in;
			indicator_bits_in = ~indicator_bits_in;
			rx_status_in = ~rx_status_in;
		end
	end
endmodule // frra_rx_framer
`default_nettype wire

// ===== verif/frra_bank_bench.sv
// Bench for the framer register bank: host accesses, frame timing and receive capture.
// Assumes a shortened frame of 40 cycles with an 8-cycle settle time.
`timescale 1ns/1ps
`default_nettype none
module frra_bank_bench import frra_pkg::*;;
	localparam int FRAME = 40;
	localparam int SETTLE = 8;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] host_addr = 8'h00;
	frra_byte_t host_wdata = 8'h00;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic clk_en = 1'b1;
	frra_byte_t host_rdata_r;
	logic host_rvalid_r, rx_frame_strobe, tx_frame_tick_r, rx_frame_tick_r, window_open_r;
	logic [12:0] rx_ops_in, indicator_bits_in, tx_ops_channel_bits_r, tx_indicator_bits_r;
	frra_byte_t rx_status_in, common_cmd_r;
	logic [1:0] event_flag_register_r;
	logic go = 1'b0;
	logic [12:0] go_ops = 13'h0000;
	logic [12:0] go_ind = 13'h0000;
	frra_byte_t go_stat = 8'h00;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	frra_bank #(.FRAME_CYC(FRAME), .SETTLE_CYC(SETTLE), .MEM_DEPTH(128)) i_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata_r(host_rdata_r),
		.host_rvalid_r(host_rvalid_r), .rx_frame_strobe(rx_frame_strobe), .rx_ops_in(rx_ops_in),
		.indicator_bits_in(indicator_bits_in), .rx_status_in(rx_status_in),
		.tx_ops_channel_bits_r(tx_ops_channel_bits_r), .tx_indicator_bits_r(tx_indicator_bits_r),
		.tx_frame_tick_r(tx_frame_tick_r), .rx_frame_tick_r(rx_frame_tick_r),
		.window_open_r(window_open_r), .event_flag_register_r(event_flag_register_r),
		.common_cmd_r(common_cmd_r));
	frra_rx_framer i_rx (.sys_clk(sys_clk), .go(go), .ops(go_ops), .indicator_bits(go_ind), .stat(go_stat),
		.rx_frame_strobe(rx_frame_strobe), .rx_ops_in(rx_ops_in),
		.indicator_bits_in(indicator_bits_in), .rx_status_in(rx_status_in));
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input frra_byte_t d);
		@(negedge sys_clk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge sys_clk);
		host_wr = 1'b0;
	endtask
	// Answer stands two edges after the read edge
	task automatic rdc(input logic [7:0] a, input frra_byte_t exp);
		@(negedge sys_clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge sys_clk);
		host_rd = 1'b0;
		@(negedge sys_clk);
		chk("read valid", 16'h0001, {15'h0, host_rvalid_r});
		chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, host_rdata_r});
	endtask
	task automatic wait_tick;
		int i;
		for (i = 0; i < 60 && tx_frame_tick_r !== 1'b1; i++)
			@(negedge sys_clk);
		chk("tx tick", 16'h0001, {15'h0, tx_frame_tick_r});
	endtask
	// Host keeps real-time accesses inside the open window
	task automatic wait_window;
		int i;
		for (i = 0; i < 60 && window_open_r !== 1'b1; i++)
			@(negedge sys_clk);
		chk("window open wait", 16'h0001, {15'h0, window_open_r});
	endtask
	task automatic t_narrow;
		wait_window();
		wr(8'h81, 8'hff);
		wr(8'h80, 8'ha5);
		wr(8'h83, 8'he2);
		wr(8'h82, 8'h3c);
		rdc(8'h82, 8'h3c);
		rdc(8'h80, 8'ha5);
		rdc(8'h81, 8'h1f);
		rdc(8'h83, 8'h02);
	endtask
	task automatic t_random;
		wr(8'hf1, 8'hc3);
		wr(8'hc0, 8'h3c);
		wr(8'ha0, 8'h5a);
		wr(8'hd1, 8'h81);
		rdc(8'hd1, 8'h81);
		rdc(8'hc0, 8'h3c);
		rdc(8'hf1, 8'hc3);
		rdc(8'ha0, 8'h5a);
		chk("common cmd", 16'h003c, {8'h00, common_cmd_r});
	endtask
	task automatic t_readonly;
		wait_window();
		wr(8'he5, 8'hff);
		rdc(8'he5, 8'h00);
		rdc(8'he8, 8'h00);
		rdc(8'h10, 8'h00);
	endtask
	task automatic t_frame;
		int n;
		int win_n;
		wait_tick();
		chk("tx ops", 16'h1fa5, {3'h0, tx_ops_channel_bits_r});
		chk("tx ind", 16'h023c, {3'h0, tx_indicator_bits_r});
		chk("window", 16'h0000, {15'h0, window_open_r});
		chk("tx flag", 16'h0001, {15'h0, event_flag_register_r[0]});
		n = 0;
		win_n = 0;
		do begin
			@(negedge sys_clk);
			n++;
			if (win_n == 0 && window_open_r === 1'b1)
				win_n = n;
		end while (tx_frame_tick_r !== 1'b1 && n < 60);
		chk("frame period", FRAME[15:0], n[15:0]);
		chk("window open", 16'h0001, {15'h0, win_n >= SETTLE - 1 && win_n <= SETTLE + 1});
		chk("tx resend", 16'h1fa5, {3'h0, tx_ops_channel_bits_r});
		rdc(8'hd0, 8'h01);
		rdc(8'hd0, 8'h00);
		wait_window();
		wr(8'h80, 8'h11);
		chk("tx hold", 16'h1fa5, {3'h0, tx_ops_channel_bits_r});
		wait_tick();
		chk("tx ops new", 16'h1f11, {3'h0, tx_ops_channel_bits_r});
	endtask
	task automatic t_rx;
		int i;
		wait_tick();
		rdc(8'hd0, 8'h01);
		@(negedge sys_clk);
		go_ops = 13'h0abc;
		go_ind = 13'h1234;
		go_stat = 8'h96;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		for (i = 0; i < 10 && rx_frame_tick_r !== 1'b1; i++)
			@(negedge sys_clk);
		chk("rx tick", 16'h0001, {15'h0, rx_frame_tick_r});
		chk("flags", 16'h0002, {14'h0, event_flag_register_r});
		wait_window();
		rdc(8'he0, 8'hbc);
		rdc(8'he1, 8'h0a);
		rdc(8'he2, 8'h34);
		rdc(8'he3, 8'h12);
		rdc(8'he5, 8'h96);
		rdc(8'hd0, 8'h02);
	endtask
	// Clock enable low for ten edges stretches the frame and drops a write
	task automatic t_freeze;
		int n;
		wait_tick();
		clk_en = 1'b0;
		wr(8'hc0, 8'h77);
		repeat (8) @(negedge sys_clk);
		chk("frozen tick", 16'h0001, {15'h0, tx_frame_tick_r});
		clk_en = 1'b1;
		n = 10;
		do begin
			@(negedge sys_clk);
			n++;
		end while (tx_frame_tick_r !== 1'b1 && n < 80);
		chk("frozen period", 16'd50, n[15:0]);
		chk("frozen write", 16'h003c, {8'h00, common_cmd_r});
	endtask
	initial begin
		repeat (5) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("flags reset", 16'h0000, {14'h0, event_flag_register_r});
		t_narrow();
		t_random();
		t_readonly();
		t_frame();
		t_rx();
		t_freeze();
		finish_test();
	end
endmodule // frra_bank_bench
`default_nettype wire
